/* File: common/sarc_regs.svh */
`ifndef SARC_REGS_SVH
`define SARC_REGS_SVH

// ============================================================
// Result word layout
`define SARC_MSB             3'd7
`define SARC_LSB             3'd0
`define SARC_RESULT_RST      8'h00
`define SARC_TRIAL_MSB       8'h80

// ============================================================
// Shift clock falling-edge counts (count value before the edge)
`define SARC_TRACK_EDGE      3'd3
`define SARC_LAST_EDGE       3'd7

// ============================================================
// Internal clock sequencing
`define SARC_HOLD_CYC        6'd4
`define SARC_CONV_CYC        6'd32
`define SARC_BIT_SUB_LAST    2'd3
`define SARC_AGE_MAX         10'h3FF

// ============================================================
// Timing limits
`define SARC_CLK_MHZ         50
`define SARC_T_CONV_MAX_US   17
`define SARC_T_CYC_FAST_US   22
`define SARC_T_CYC_SLOW_US   25
`define SARC_CONV_MAX_CYC    (`SARC_T_CONV_MAX_US * `SARC_CLK_MHZ)
`define SARC_CYC_FAST_CYC    (`SARC_T_CYC_FAST_US * `SARC_CLK_MHZ)
`define SARC_CYC_SLOW_CYC    (`SARC_T_CYC_SLOW_US * `SARC_CLK_MHZ)

`endif

/* File: common/sarc_pkg.sv */
`include "sarc_regs.svh"

package sarc_pkg;

  typedef enum logic [1:0]
  {
    sarc_idle,
    sarc_hold,
    sarc_conv
  } sarc_state_t;

  // Bit position presented or decided at step n, MSB first
  function automatic logic [2:0] sarc_bit_idx(input logic [2:0] n);
    sarc_bit_idx = `SARC_MSB - n;
  endfunction

endpackage

/* File: logic/sarc_sel_filter.sv */
`timescale 1ns/1ps
`include "sarc_regs.svh"

module sarc_sel_filter
  import sarc_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic srst_i,
  input  wire logic sel_n_i,
  output logic      sel_low_o
);

  logic sync1_r;
  logic sync2_r;

  // ============================================================
  // Two rising edges, then one falling edge, before select counts
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
    end
    else
    begin
      sync1_r <= sel_n_i;
      sync2_r <= sync1_r;
    end
  end

  always_ff @(negedge clk_i)
  begin
    if (srst_i)
      sel_low_o <= 1'b0;
    else
      sel_low_o <= ~sync2_r;
  end

endmodule // sarc_sel_filter

/* File: logic/sarc_top.sv */
`timescale 1ns/1ps
`include "sarc_regs.svh"

// Function
// - Select high: output floats, shift clock activity ignored.
// - Select fall accepted after two rising and one falling internal edge.
// - Select rise floats output at once; logic deselects after filter delay.
// - Select low shows MSB of previous result before any shift edge.
// - Falling edges one to four present result bits two to five.
// - Tracking starts after fourth falling edge, lasts to eighth.
// - Falling edges five to seven present bits six to eight.
// - Eighth falling edge switches from tracking to hold.
// - Hold four internal cycles, convert thirty-two, done after thirty-six.
// - Select may stay low; edge count continues; no clock glitches.
// - Valid select fall during conversion aborts it.
// - New eight-edge sequence aborts conversion, restarts, old result out.
// - Acquisition window is four shift clock cycles.
// - Conversion finishes within seventeen microseconds of hold.
// - Full cycle repeatable within twenty-two or twenty-five microseconds.
// - Internal and shift clocks fully independent.
// - Straight binary coding: zero gives all zeros, full scale all ones.

module sarc_top
  import sarc_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  input  wire logic       io_clk_i,
  input  wire logic       sel_n_i,
  input  wire logic       cmp_i,
  output logic            data_o,
  output logic            data_oe_o,
  output logic            track_o,
  output logic            hold_o,
  output logic [7:0]      dac_code_o
);

  localparam int CONV_MAX_CYC = `SARC_CONV_MAX_CYC;
  localparam int CYC_FAST_CYC = `SARC_CYC_FAST_CYC;

  // ============================================================
  // Select filter and frame tracking (internal clock)
  logic        sel_low_w;
  logic        frame_r;
  logic        frame_d_r;
  logic        frame_start_w;
  logic        link_rst_w;

  sarc_sel_filter u_sel_filter
  (
    .clk_i     (clk_i),
    .srst_i    (srst_i),
    .sel_n_i   (sel_n_i),
    .sel_low_o (sel_low_w)
  );

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      frame_r   <= 1'b0;
      frame_d_r <= 1'b0;
    end
    else
    begin
      frame_r   <= sel_low_w;
      frame_d_r <= frame_r;
    end
  end

  assign frame_start_w = frame_r & ~frame_d_r;
  // Link logic held cleared while deselected
  assign link_rst_w    = ~frame_r;

  // ============================================================
  // Link side: shift clock falling edges
  logic [2:0]  cnt_r;
  logic        hold_tgl_r;

  // Count wraps so back-to-back frames keep going
  always_ff @(negedge io_clk_i or posedge link_rst_w)
  begin
    if (link_rst_w)
      cnt_r <= 3'h0;
    else
      cnt_r <= cnt_r + 3'h1;
  end

  // Track from fourth to eighth edge
  always_ff @(negedge io_clk_i or posedge link_rst_w)
  begin
    if (link_rst_w)
      track_o <= 1'b0;
    else if (cnt_r == `SARC_TRACK_EDGE)
      track_o <= 1'b1;
    else if (cnt_r == `SARC_LAST_EDGE)
      track_o <= 1'b0;
  end

  // Eighth edge leaves as a toggle; shift clock may stop right after
  always_ff @(negedge io_clk_i or posedge link_rst_w)
  begin
    if (link_rst_w)
      hold_tgl_r <= 1'b0;
    else if (cnt_r == `SARC_LAST_EDGE)
      hold_tgl_r <= ~hold_tgl_r;
  end

  // ============================================================
  // Toggle crossing into internal clock
  logic        htg_s1_r;
  logic        htg_s2_r;
  logic        htg_s3_r;
  logic        hold_evt_w;

  // Two-flop sync; no phase relation assumed
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      htg_s1_r <= 1'b0;
      htg_s2_r <= 1'b0;
      htg_s3_r <= 1'b0;
    end
    else
    begin
      htg_s1_r <= hold_tgl_r;
      htg_s2_r <= htg_s1_r;
      htg_s3_r <= htg_s2_r;
    end
  end

  // Toggle reset at deselect is masked by frame
  assign hold_evt_w = (htg_s2_r ^ htg_s3_r) & frame_r;

  // ============================================================
  // Data output
  logic [7:0]  result_r;

  // Count selects bit; result updates only when a conversion completes
  assign data_o    = result_r[sarc_bit_idx(cnt_r)];
  // Pin itself floats the output without filter delay
  assign data_oe_o = ~sel_n_i & frame_r;

  // ============================================================
  // Hold and conversion sequencer
  sarc_state_t state_r;
  sarc_state_t state_nxt;
  logic [5:0]  cyc_r;
  logic [5:0]  cyc_nxt;
  logic [7:0]  sar_r;
  logic [7:0]  sar_nxt;
  logic [7:0]  result_nxt;
  logic [2:0]  bit_w;
  logic        bit_end_w;
  logic        conv_done_w;

  assign bit_w       = sarc_bit_idx(cyc_r[4:2]);
  assign bit_end_w   = (state_r == sarc_conv) && (cyc_r[1:0] == `SARC_BIT_SUB_LAST);
  assign conv_done_w = (state_r == sarc_conv) && (cyc_r == `SARC_CONV_CYC - 6'd1) &&
                       !frame_start_w && !hold_evt_w;

  always_comb
  begin
    state_nxt  = state_r;
    cyc_nxt    = cyc_r;
    sar_nxt    = sar_r;
    result_nxt = result_r;
    if (frame_start_w)
    begin
      state_nxt = sarc_idle;
      cyc_nxt   = 6'h00;
    end
    else if (hold_evt_w)
    begin
      // Eighth edge starts a fresh hold
      state_nxt = sarc_hold;
      cyc_nxt   = 6'h00;
    end
    else
    begin
      case (state_r)
        sarc_hold:
        begin
          if (cyc_r == `SARC_HOLD_CYC - 6'd1)
          begin
            state_nxt = sarc_conv;
            cyc_nxt   = 6'h00;
            sar_nxt   = `SARC_TRIAL_MSB;
          end
          else
            cyc_nxt = cyc_r + 6'h01;
        end
        sarc_conv:
        begin
          // Keep bit while input is at or above trial code
          if (bit_end_w)
          begin
            sar_nxt[bit_w] = cmp_i;
            if (bit_w != `SARC_LSB)
              sar_nxt[bit_w - 3'd1] = 1'b1;
          end
          if (cyc_r == `SARC_CONV_CYC - 6'd1)
          begin
            state_nxt  = sarc_idle;
            cyc_nxt    = 6'h00;
            result_nxt = {sar_r[7:1], cmp_i};
          end
          else
            cyc_nxt = cyc_r + 6'h01;
        end
        default:
          cyc_nxt = 6'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      state_r  <= sarc_idle;
      cyc_r    <= 6'h00;
      sar_r    <= `SARC_RESULT_RST;
      result_r <= `SARC_RESULT_RST;
    end
    else
    begin
      state_r  <= state_nxt;
      cyc_r    <= cyc_nxt;
      sar_r    <= sar_nxt;
      result_r <= result_nxt;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      hold_o     <= 1'b0;
      dac_code_o <= `SARC_RESULT_RST;
    end
    else
    begin
      hold_o     <= (state_nxt != sarc_idle);
      dac_code_o <= sar_nxt;
    end
  end

  // ============================================================
  // Checks
  logic [9:0]  age_r;

  always_ff @(posedge clk_i)
  begin
    if (srst_i || hold_evt_w)
      age_r <= 10'h000;
    else if (age_r != `SARC_AGE_MAX)
      age_r <= age_r + 10'h001;
  end

  property p_float_high;
    @(posedge clk_i) disable iff (srst_i)
    sel_n_i |-> !data_oe_o && (frame_r || (cnt_r == 3'h0 && !track_o));
  endproperty
  a_float_high: assert property (p_float_high) else $error("output driven while deselected");

  property p_filter;
    @(posedge clk_i) disable iff (srst_i)
    $rose(frame_r) |-> !$past(sel_n_i, 1) && !$past(sel_n_i, 2);
  endproperty
  a_filter: assert property (p_filter) else $error("select fall taken too early");

  property p_deselect;
    @(posedge clk_i) disable iff (srst_i)
    sel_n_i [*3] |=> !frame_r;
  endproperty
  a_deselect: assert property (p_deselect) else $error("deselect not registered");

  property p_msb_first;
    @(posedge clk_i) disable iff (srst_i)
    $rose(frame_r) |-> data_o == result_r[7];
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("MSB not shown at frame start");

  property p_count;
    @(negedge io_clk_i) disable iff (link_rst_w)
    1'b1 |=> cnt_r == 3'($past(cnt_r) + 3'h1);
  endproperty
  a_count: assert property (p_count) else $error("edge count skipped");

  property p_track_window;
    @(negedge io_clk_i) disable iff (link_rst_w)
    (cnt_r == `SARC_TRACK_EDGE) |=> track_o [*4] ##1 !track_o;
  endproperty
  a_track_window: assert property (p_track_window) else $error("track window wrong");

  property p_hold_start;
    @(posedge clk_i) disable iff (srst_i)
    (hold_evt_w && !frame_start_w) |=> state_r == sarc_hold && cyc_r == 6'h00 && hold_o;
  endproperty
  a_hold_start: assert property (p_hold_start) else $error("hold not restarted");

  property p_conv_len;
    @(posedge clk_i) disable iff (srst_i)
    conv_done_w |-> age_r == 10'(`SARC_HOLD_CYC + `SARC_CONV_CYC - 6'd1);
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion not 36 cycles");

  property p_conv_max;
    @(posedge clk_i) disable iff (srst_i)
    conv_done_w |-> (int'(age_r) < CONV_MAX_CYC) && (int'(age_r) < CYC_FAST_CYC);
  endproperty
  a_conv_max: assert property (p_conv_max) else $error("conversion too slow");

  property p_abort;
    @(posedge clk_i) disable iff (srst_i)
    frame_start_w |=> state_r == sarc_idle && !hold_o;
  endproperty
  a_abort: assert property (p_abort) else $error("reselect did not abort");

  property p_keep_bit;
    @(posedge clk_i) disable iff (srst_i)
    (bit_end_w && cmp_i && !frame_start_w && !hold_evt_w) |=> sar_r[$past(bit_w)];
  endproperty
  a_keep_bit: assert property (p_keep_bit) else $error("decided bit lost");
  c_frame:  cover property (@(posedge clk_i) disable iff (srst_i) $rose(frame_r));
  c_hold:   cover property (@(posedge clk_i) disable iff (srst_i) hold_evt_w);
  c_done:   cover property (@(posedge clk_i) disable iff (srst_i) conv_done_w);
  c_abort:  cover property (@(posedge clk_i) disable iff (srst_i)
                            frame_start_w && state_r != sarc_idle);

endmodule // sarc_top

/* File: verification/sarc_ctrl_model.sv */
`timescale 1ns/1ps

module sarc_ctrl_model
(
  input  wire logic clk_i,
  input  wire logic data_i,
  input  wire logic data_oe_i,
  input  wire logic track_i,
  output logic      sel_n_o,
  output logic      io_clk_o
);
  logic lclk = 1'b0;
  logic gate = 1'b0;
  logic last = 1'b0;
  // Released line shows the inverse of the last driven bit
  wire  line = data_oe_i ? data_i : ~last;

  initial sel_n_o = 1'b1;
  initial #1.7 forever #3 lclk = ~lclk;
  assign io_clk_o = lclk & gate;

  always @(posedge clk_i)
    if (data_oe_i)
      last <= data_i;

  task automatic pulses(input int n, output logic [7:0] rx, output logic [7:0] trk);
    rx = 8'h00;
    trk = 8'h00;
    repeat (n)
    begin
      @(negedge lclk) gate = 1'b1;
      @(posedge lclk) rx = {rx[6:0], line};
      trk = {trk[6:0], track_i};
      @(negedge lclk) gate = 1'b0;
    end
  endtask

  // Setup margin well past the select filter
  task automatic select();
    @(posedge clk_i) sel_n_o <= 1'b0;
    repeat (10) @(posedge clk_i);
  endtask

  // let the hold event land first
  task automatic deselect();
    repeat (5) @(posedge clk_i);
    sel_n_o <= 1'b1;
    repeat (6) @(posedge clk_i);
  endtask
endmodule // sarc_ctrl_model

/* File: verification/sarc_top_bench.sv */
`timescale 1ns/1ps

module sarc_top_bench;
  typedef struct {logic [7:0] vin; logic [7:0] expv;} sarc_row_t;

  logic       clk_i = 1'b0;
  logic       srst_i = 1'b1;
  logic       cmp_i = 1'b0;
  logic [7:0] vin = 8'h00;
  logic [7:0] hcnt = 8'h00;
  logic [7:0] rx;
  logic [7:0] trk;
  wire        sel_n;
  wire        io_clk;
  wire        data_o;
  wire        data_oe_o;
  wire        track_o;
  wire        hold_o;
  wire  [7:0] dac_code_o;
  int         failures = 0;
  int         n_checks = 0;
  sarc_row_t  rows [6] = '{'{8'h00, 8'h00}, '{8'hFF, 8'h00}, '{8'hA5, 8'hFF},
                           '{8'h5A, 8'hA5}, '{8'h01, 8'h5A}, '{8'h80, 8'h01}};

  sarc_top uut (.clk_i(clk_i), .srst_i(srst_i), .io_clk_i(io_clk), .sel_n_i(sel_n),
                .cmp_i(cmp_i), .data_o(data_o), .data_oe_o(data_oe_o), .track_o(track_o),
                .hold_o(hold_o), .dac_code_o(dac_code_o));

  sarc_ctrl_model ctl (.clk_i(clk_i), .data_i(data_o), .data_oe_i(data_oe_o),
                       .track_i(track_o), .sel_n_o(sel_n), .io_clk_o(io_clk));

  always #10 clk_i = ~clk_i;

  // Ideal comparator; one cycle lag is covered by the bit period
  always @(posedge clk_i)
    cmp_i <= (vin >= dac_code_o);

  always @(posedge clk_i)
    if (hold_o === 1'b1)
      hcnt <= hcnt + 8'h01;

  task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic close_out();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // One full select frame that starts a conversion of v
  task automatic frame(input logic [7:0] v, input logic [7:0] e, input string nm);
    logic [7:0] h0;
    vin <= v;
    // Hold counter has one driver; take a baseline instead of clearing it
    @(posedge clk_i) h0 = hcnt;
    ctl.select();
    check({nm, " oe"}, 8'h01, {7'h00, data_oe_o});
    ctl.pulses(8, rx, trk);
    check(nm, e, rx);
    check({nm, " track"}, 8'h0F, trk);
    ctl.deselect();
    check({nm, " float"}, 8'h00, {7'h00, data_oe_o});
    repeat (45) @(posedge clk_i);
    check({nm, " hold"}, 8'h24, 8'(hcnt - h0));
    $display("test %s done", nm);
  endtask

  initial
  begin
    #100us;
    failures++;
    close_out();
  end

  initial
  begin
    repeat (10) @(posedge clk_i);
    srst_i <= 1'b0;
    foreach (rows[i])
      frame(rows[i].vin, rows[i].expv, $sformatf("row%0d", i));
    // Shift clock with select high must not move the count
    ctl.pulses(3, rx, trk);
    check("idle track", 8'h00, trk);
    frame(8'h33, 8'h80, "idle clk");
    // Select held low over two conversions
    vin <= 8'h44;
    ctl.select();
    ctl.pulses(8, rx, trk);
    check("b2b first", 8'h33, rx);
    repeat (45) @(posedge clk_i);
    vin <= 8'h27;
    ctl.pulses(8, rx, trk);
    check("b2b second", 8'h44, rx);
    // Third sequence lands mid conversion: restart, earlier result out
    repeat (10) @(posedge clk_i);
    vin <= 8'h5C;
    ctl.pulses(8, rx, trk);
    check("b2b early", 8'h44, rx);
    ctl.deselect();
    repeat (45) @(posedge clk_i);
    $display("test b2b done");
    // Early reselect aborts, old result still shown
    vin <= 8'h99;
    ctl.select();
    ctl.pulses(8, rx, trk);
    ctl.deselect();
    vin <= 8'h66;
    ctl.select();
    check("abort hold", 8'h00, {7'h00, hold_o});
    ctl.pulses(8, rx, trk);
    check("abort read", 8'h5C, rx);
    ctl.deselect();
    repeat (45) @(posedge clk_i);
    $display("test abort done");
    frame(8'h00, 8'h66, "after abort");
    // Reset during the hold phase clears the result
    ctl.select();
    ctl.pulses(8, rx, trk);
    repeat (5) @(posedge clk_i);
    srst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    check("reset float", 8'h00, {7'h00, data_oe_o});
    srst_i <= 1'b0;
    @(posedge clk_i);
    check("reset hold", 8'h00, {7'h00, hold_o});
    ctl.deselect();
    $display("test reset done");
    frame(8'h00, 8'h00, "after reset");
    close_out();
  end
endmodule // sarc_top_bench
